// ==== logic/comp_cfg_pkg.sv ====
// comparator configuration constants: register address, field layout, reset value, response timing
// assumes a 250 MHz system clock and a simple memory-mapped register port
// Function
// RULE1 - bit 8 powers the comparator up when 1, down when 0
// RULE2 - bits 7:6 pick negative input: half supply, input five, channel seven, unused
// RULE3 - bits 5:4 connect the comparator result to interrupt logic when set
// RULE4 - bit 3 inverts result: 0 high when plus above minus, 1 when below
// RULE5 - bits 2:1 set falling response 6, 4, 4 or 3 us; rising stays 6 us
// RULE6 - the register resets to 0x0000: off, unrouted, slowest, no hysteresis
// RULE7 - bit 0 enables hysteresis; bits 15:9 read zero and ignore writes
package comp_cfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] COMPARATOR_CONFIG_ADDR = 32'h4008_7838;
  localparam logic [15:0] COMPARATOR_CONFIG_RST = 16'h0000;
  localparam logic [15:0] COMPARATOR_CONFIG_MASK = 16'h01FF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 8;
  localparam int NEG_SEL_HI = 7;
  localparam int NEG_SEL_LO = 6;
  localparam int ROUTE_HI = 5;
  localparam int ROUTE_LO = 4;
  localparam int POLARITY_BIT = 3;
  localparam int SPEED_HI = 2;
  localparam int SPEED_LO = 1;
  localparam int THRESH_BAND_BIT = 0;

  // negative input codes
  typedef enum logic [1:0] {
    NEG_HALF_SUPPLY = 2'h0,
    NEG_INPUT_FIVE = 2'h1,
    NEG_CHANNEL_SEVEN = 2'h2,
    NEG_UNUSED = 2'h3
  } neg_sel_t;

  // ----------------------------------------------------------------
  // response timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int T_RISE_NS = 6000;
  localparam int T_FALL0_NS = 6000;
  localparam int T_FALL1_NS = 4000;
  localparam int T_FALL2_NS = 4000;
  localparam int T_FALL3_NS = 3000;
  localparam int RISE_CYC = T_RISE_NS * CLK_MHZ / 1000;
  localparam int FALL0_CYC = T_FALL0_NS * CLK_MHZ / 1000;
  localparam int FALL1_CYC = T_FALL1_NS * CLK_MHZ / 1000;
  localparam int FALL2_CYC = T_FALL2_NS * CLK_MHZ / 1000;
  localparam int FALL3_CYC = T_FALL3_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 11;

endpackage : comp_cfg_pkg

// ==== logic/resp_settle.sv ====
// settle timer: output follows the input once it has held a new level for the edge's count
// assumes counts fit CNT_W bits and are at least one; reset is already synchronised
`timescale 1ns/1ns
module resp_settle
  import comp_cfg_pkg::*;
#(
  parameter int W = CNT_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic en_i,
  input wire logic raw_i,
  input wire logic [W-1:0] rise_cnt_i,
  input wire logic [W-1:0] fall_cnt_i,
  // result
  output logic settled_o
);

  // refuse a counter too narrow to hold any useful settle count
  if (W < 2)
  begin : g_width_check
    $error("resp_settle: width too small");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  logic [W-1:0] target;

  // a change is only accepted after it stays put; short glitches restart the count
  always_comb
  begin
    cnt_nxt = '0;
    out_nxt = out_r;
    target = raw_i ? rise_cnt_i : fall_cnt_i; // RULE5
    if (!en_i)
    begin
      out_nxt = 1'b0;
    end
    else if (raw_i != out_r)
    begin
      if (cnt_r + W'(1) >= target)
      begin
        out_nxt = raw_i;
      end
      else
      begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign settled_o = out_r;

endmodule : resp_settle

// ==== logic/comparator_control_regs.sv ====
// comparator configuration register and the digital side of the comparator result path
// assumes the register port is synchronous to clk_i and the analog comparator result arrives as a synchronous level
`timescale 1ns/1ns
module comparator_control_regs
  import comp_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic sel_i,
  input wire logic wr_i,
  input wire logic [31:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic ack_o,
  output logic err_o,
  // analog comparator controls
  output logic comp_enable_o,
  output logic [1:0] negative_input_select_o,
  output logic half_supply_sel_o,
  output logic analog_input_five_sel_o,
  output logic converter_channel_seven_sel_o,
  output logic polarity_flip_o,
  output logic [1:0] speed_sel_o,
  output logic thresh_band_enable_o,
  // comparator result
  input wire logic cmp_raw_i,
  output logic cmp_state_o,
  output logic cmp_event_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  // asynchronous assert, synchronous release through two flops
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic [15:0] rdata_nxt;
  logic ack_nxt;
  logic err_nxt;
  logic hit;

  // only one word is mapped; anything else answers with an error and no effect
  always_comb
  begin
    hit = sel_i && (addr_i == COMPARATOR_CONFIG_ADDR);
    cfg_nxt = cfg_r;
    rdata_nxt = 16'h0000;
    ack_nxt = sel_i;
    err_nxt = sel_i && !hit;
    if (hit && wr_i)
    begin
      cfg_nxt = wdata_i & COMPARATOR_CONFIG_MASK; // RULE7
    end
    if (hit && !wr_i)
    begin
      rdata_nxt = cfg_r & COMPARATOR_CONFIG_MASK; // RULE7
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_r <= COMPARATOR_CONFIG_RST; // RULE6
      rdata_o <= 16'h0000;
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      rdata_o <= rdata_nxt;
      ack_o <= ack_nxt;
      err_o <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // field decode to the analog side
  // ----------------------------------------------------------------
  logic en_f;
  logic route_f;
  logic [1:0] neg_f;

  // control outputs follow the stored register one cycle later so every output is a flop
  always_comb
  begin
    en_f = cfg_r[ENABLE_BIT]; // RULE1
    neg_f = cfg_r[NEG_SEL_HI:NEG_SEL_LO];
    route_f = cfg_r[ROUTE_HI:ROUTE_LO] != 2'h0; // RULE3
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comp_enable_o <= 1'b0;
      negative_input_select_o <= 2'h0;
      half_supply_sel_o <= 1'b0;
      analog_input_five_sel_o <= 1'b0;
      converter_channel_seven_sel_o <= 1'b0;
      polarity_flip_o <= 1'b0;
      speed_sel_o <= 2'h0;
      thresh_band_enable_o <= 1'b0;
    end
    else
    begin
      comp_enable_o <= en_f; // RULE1
      negative_input_select_o <= neg_f; // RULE2
      // the unused code selects no source so the negative node is left floating, not shorted
      half_supply_sel_o <= en_f && (neg_f == NEG_HALF_SUPPLY); // RULE2
      analog_input_five_sel_o <= en_f && (neg_f == NEG_INPUT_FIVE); // RULE2
      converter_channel_seven_sel_o <= en_f && (neg_f == NEG_CHANNEL_SEVEN); // RULE2
      polarity_flip_o <= cfg_r[POLARITY_BIT]; // RULE4
      speed_sel_o <= cfg_r[SPEED_HI:SPEED_LO]; // RULE5
      thresh_band_enable_o <= cfg_r[THRESH_BAND_BIT]; // RULE7
    end
  end

  // ----------------------------------------------------------------
  // result path: polarity, response time, interrupt routing
  // ----------------------------------------------------------------
  logic oriented;
  logic settled;
  logic [CNT_W-1:0] fall_cnt;
  logic state_nxt;
  logic event_nxt;

  // falling response depends on the speed code, rising is fixed at the slow figure
  always_comb
  begin
    oriented = cmp_raw_i ^ cfg_r[POLARITY_BIT]; // RULE4
    unique case (cfg_r[SPEED_HI:SPEED_LO]) // RULE5
      2'h0: fall_cnt = CNT_W'(FALL0_CYC);
      2'h1: fall_cnt = CNT_W'(FALL1_CYC);
      2'h2: fall_cnt = CNT_W'(FALL2_CYC);
      2'h3: fall_cnt = CNT_W'(FALL3_CYC);
    endcase
  end

  resp_settle #(
    .W(CNT_W)
  ) u_settle (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(en_f),
    .raw_i(oriented),
    .rise_cnt_i(CNT_W'(RISE_CYC)),
    .fall_cnt_i(fall_cnt),
    .settled_o(settled)
  );

  // a powered-down comparator reports low and raises no events
  always_comb
  begin
    state_nxt = en_f && settled; // RULE1
    event_nxt = route_f && state_nxt && !cmp_state_o; // RULE3
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_state_o <= 1'b0;
      cmp_event_o <= 1'b0;
    end
    else
    begin
      cmp_state_o <= state_nxt;
      cmp_event_o <= event_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  property p_enable_follows;
    $rose(cfg_r[ENABLE_BIT]) |=> comp_enable_o;
  endproperty
  a_enable_follows: assert property (p_enable_follows) else $error("enable output missed bit 8"); // RULE1

  property p_neg_decode;
    ##1 (half_supply_sel_o == ($past(cfg_r[ENABLE_BIT]) && $past(cfg_r[7:6]) == 2'h0))
      && (analog_input_five_sel_o == ($past(cfg_r[ENABLE_BIT]) && $past(cfg_r[7:6]) == 2'h1))
      && (converter_channel_seven_sel_o == ($past(cfg_r[ENABLE_BIT]) && $past(cfg_r[7:6]) == 2'h2));
  endproperty
  a_neg_decode: assert property (p_neg_decode) else $error("negative input decode wrong"); // RULE2

  property p_no_event_unrouted;
    (cfg_r[5:4] == 2'h0) |=> !cmp_event_o;
  endproperty
  a_no_event_unrouted: assert property (p_no_event_unrouted) else $error("event while unrouted"); // RULE3

  property p_polarity_out;
    ##1 polarity_flip_o == $past(cfg_r[3]);
  endproperty
  a_polarity_out: assert property (p_polarity_out) else $error("polarity output stale"); // RULE4

  property p_rise_time;
    // start from a low oriented level so the settle count is known to restart from zero
    cfg_r[ENABLE_BIT] && !settled && !oriented ##1 (cfg_r[ENABLE_BIT] && oriented)[*8] |-> !settled;
  endproperty
  a_rise_time: assert property (p_rise_time) else $error("rise settled too fast"); // RULE5

  property p_reset_value;
    $rose(rst_n) |-> cfg_r == 16'h0000 && !comp_enable_o;
  endproperty
  a_reset_value: assert property (@(posedge clk_i) p_reset_value) else $error("reset value wrong"); // RULE6

  property p_reserved_zero;
    ack_o && !err_o |-> rdata_o[15:9] == 7'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // RULE7

  property p_write_hys;
    sel_i && wr_i && addr_i == 32'h4008_7838 ##1 1 |-> ##1 thresh_band_enable_o == $past(wdata_i[0], 2);
  endproperty
  a_write_hys: assert property (p_write_hys) else $error("hysteresis bit not written"); // RULE7

  c_write: cover property (sel_i && wr_i && !err_o ##1 ack_o);
  c_unmapped: cover property (err_o);
  c_event: cover property (cmp_event_o);

endmodule : comparator_control_regs

// ==== verification/comparator_control_regs_tb_top.sv ====
// bench for the comparator configuration register and its result path
// assumes the design answers every access one cycle later and drives only the registered outputs
`timescale 1ns/1ns
module comparator_control_regs_tb_top;
  import comp_cfg_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sel_i = 1'b0;
  logic wr_i = 1'b0;
  logic [31:0] addr_i = 32'h0;
  logic [15:0] wdata_i = 16'h0;
  logic cmp_raw_i = 1'b1;
  logic [15:0] rdata_o;
  logic ack_o, err_o, comp_enable_o, half_supply_sel_o, analog_input_five_sel_o;
  logic converter_channel_seven_sel_o, polarity_flip_o, thresh_band_enable_o, cmp_state_o, cmp_event_o;
  logic [1:0] negative_input_select_o, speed_sel_o;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [15:0] rd;
  int n;
  logic ev;

  comparator_control_regs u_comparator_control_regs (
    .clk_i(clk_i), .nrst_i(nrst_i), .sel_i(sel_i), .wr_i(wr_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o), .err_o(err_o),
    .comp_enable_o(comp_enable_o), .negative_input_select_o(negative_input_select_o),
    .half_supply_sel_o(half_supply_sel_o), .analog_input_five_sel_o(analog_input_five_sel_o),
    .converter_channel_seven_sel_o(converter_channel_seven_sel_o), .polarity_flip_o(polarity_flip_o),
    .speed_sel_o(speed_sel_o), .thresh_band_enable_o(thresh_band_enable_o),
    .cmp_raw_i(cmp_raw_i), .cmp_state_o(cmp_state_o), .cmp_event_o(cmp_event_o)
  );

  // 250 MHz system clock
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one access; the answer is taken one edge after the request edge
  task acc(input logic w, input logic [31:0] a, input logic [15:0] d, input logic e, output logic [15:0] q);
    @(posedge clk_i);
    sel_i <= 1'b1;
    wr_i <= w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    sel_i <= 1'b0;
    #1;
    q = rdata_o;
    chk({15'h0, ack_o}, 16'h0001);
    chk({15'h0, err_o}, {15'h0, e});
  endtask : acc

  // let the control outputs land, then compare them all as one word
  // word layout: enable 9, neg select 8:7, half 6, five 5, seven 4, flip 3, speed 2:1, band 0
  task ctl(input logic [15:0] exp);
    @(posedge clk_i);
    #1;
    chk({6'h00, comp_enable_o, negative_input_select_o, half_supply_sel_o, analog_input_five_sel_o,
         converter_channel_seven_sel_o, polarity_flip_o, speed_sel_o, thresh_band_enable_o}, exp);
  endtask : ctl

  // bounded wait for the settled result; a hang counts as a mismatch
  task wait_state(input logic v, output int cnt, output logic e);
    for (cnt = 0; cnt < 3000; cnt++)
    begin
      @(posedge clk_i);
      #1;
      if (cmp_state_o === v)
        break;
    end
    e = cmp_event_o;
    if (cnt >= 3000)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, cmp_state_o, v);
      end_of_test();
    end
  endtask : wait_state

  // settle time lies within a few cycles of the nominal count
  task chk_cnt(input int cnt, input int nom);
    chk({15'h0, (cnt >= nom - 4) && (cnt <= nom + 4)}, 16'h0001);
  endtask : chk_cnt

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk({15'h0, cmp_state_o}, 16'h0000);
    acc(1'b0, COMPARATOR_CONFIG_ADDR, 16'h0, 1'b0, rd);
    chk(rd, 16'h0000);
    ctl(16'h0000);
    // reserved bits dropped, every field but the route reaches its output
    acc(1'b1, COMPARATOR_CONFIG_ADDR, 16'hFFFF, 1'b0, rd);
    ctl(16'h038F);
    acc(1'b0, COMPARATOR_CONFIG_ADDR, 16'h0, 1'b0, rd);
    chk(rd, 16'h01FF);
    // every negative input code while enabled: one-hot for the three sources, no select for the unused code
    for (int c = 0; c < 4; c++)
    begin
      acc(1'b1, COMPARATOR_CONFIG_ADDR, 16'h0100 | 16'(c << 6), 1'b0, rd);
      ctl(16'h0200 | 16'(c << 7) | 16'((c < 3) ? (8'h40 >> c) : 8'h00));
    end
    acc(1'b1, COMPARATOR_CONFIG_ADDR, 16'h0040, 1'b0, rd);
    ctl(16'h0080);
    // unmapped address: refused, register untouched
    acc(1'b1, COMPARATOR_CONFIG_ADDR + 32'h4, 16'h01FF, 1'b1, rd);
    acc(1'b0, COMPARATOR_CONFIG_ADDR + 32'h4, 16'h0, 1'b1, rd);
    chk(rd, 16'h0000);
    acc(1'b0, COMPARATOR_CONFIG_ADDR, 16'h0, 1'b0, rd);
    chk(rd, 16'h0040);
    // enabled, routed, fastest fall: rise takes the rising count and raises an event
    acc(1'b1, COMPARATOR_CONFIG_ADDR, 16'h0116, 1'b0, rd);
    wait_state(1'b1, n, ev);
    chk_cnt(n, RISE_CYC);
    chk({15'h0, ev}, 16'h0001);
    @(posedge clk_i);
    #1;
    chk({15'h0, cmp_event_o}, 16'h0000);
    // polarity flipped with raw still high: result falls at the speed-3 count
    acc(1'b1, COMPARATOR_CONFIG_ADDR, 16'h011E, 1'b0, rd);
    wait_state(1'b0, n, ev);
    chk_cnt(n, FALL3_CYC);
    // unrouted: raw low with flip gives a rise but no event
    acc(1'b1, COMPARATOR_CONFIG_ADDR, 16'h010E, 1'b0, rd);
    @(posedge clk_i);
    cmp_raw_i <= 1'b0;
    wait_state(1'b1, n, ev);
    chk_cnt(n, RISE_CYC);
    chk({15'h0, ev}, 16'h0000);
    // remaining fall speeds, each followed by a rise back at the fixed rising count
    for (int s = 0; s < 3; s++)
    begin
      acc(1'b1, COMPARATOR_CONFIG_ADDR, 16'h0108 | 16'(s << 1), 1'b0, rd);
      @(posedge clk_i);
      cmp_raw_i <= 1'b1;
      wait_state(1'b0, n, ev);
      chk_cnt(n, (s == 0) ? FALL0_CYC : ((s == 1) ? FALL1_CYC : FALL2_CYC));
      @(posedge clk_i);
      cmp_raw_i <= 1'b0;
      wait_state(1'b1, n, ev);
      chk_cnt(n, RISE_CYC);
    end
    // powered down: result drops at once
    acc(1'b1, COMPARATOR_CONFIG_ADDR, 16'h000E, 1'b0, rd);
    repeat (2) @(posedge clk_i);
    #1;
    chk({15'h0, cmp_state_o}, 16'h0000);
    // reset in mid-run: the register returns to its reset value
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    acc(1'b0, COMPARATOR_CONFIG_ADDR, 16'h0, 1'b0, rd);
    chk(rd, 16'h0000);
    end_of_test();
  end

endmodule : comparator_control_regs_tb_top
